// [hdl/raw_block_framer.sv]
// Framer for the binary raw single-frequency measurement block.
// Assumes header and records come from same-clock logic, and that the
// byte sink (serial transmitter) is on the same clock too.
//
// Notes on behaviour
// - Block: header, length, 5-byte time tag, parameter byte, 14-byte records, checksum, end.
// - First two time-tag bytes carry the full, unambiguous week count.
// - Last three time-tag bytes carry time in week in tenths of a second.
// - Parameter bits 0-1 encode the code smoothing interval.
// - Parameter bit 2 set, bit 3 clear, bits 4-6 reserved, bit 7 clear.
// - Record opens with satellite number then four-byte pseudorange.
// - Sixth record byte bits 0-4 hold C/N0 minus 26 dB-Hz.
// - Sixth record byte bit 7 set when carrier phase is invalid.
// - Three bytes of carrier phase in thousandths of a cycle follow.
// - Three bytes signed carrier rate; 800000 hex marks it invalid.
// - Quality bits 0-4 count continuity losses per satellite, modulo 32.
// - Quality bits 5-7 carry the phase error class.
// - Last byte bits 0-3 multipath class, 1111 when undetermined.
// - Last byte bits 4-7 carry the pseudorange error class.
// - Block opens with FE and closes with FF.
// - Content bytes FD, FE, FF go out as FD then 00, 01, 02.
// - Checksum is the 16-bit sum of unescaped bytes after start, before checksum.
// - Length counts unescaped bytes after start up to the checksum.
`include "raw_block_params.svh"
`timescale 1ns/1ps
`default_nettype none

module raw_block_framer #(
  parameter int FIFO_DEPTH = `RB_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire raw_block_pkg::blk_hdr_t i_hdr,
  input wire raw_block_pkg::sv_rec_t i_rec,
  input wire logic i_rec_valid,
  output logic o_rec_ready,
  output logic [7:0] o_byte,
  output logic o_byte_valid,
  input wire logic i_byte_ready,
  output logic o_busy
);
  import raw_block_pkg::*;

  // ----------------------------------------
  // Field encoders
  // ----------------------------------------

  // Level field saturates: below the offset reads 0, above the range 31
  function automatic logic [4:0] level_field(input logic [7:0] cn0);
    logic [7:0] d;
    d = cn0 - `RB_CN0_OFS;
    if (cn0 < `RB_CN0_OFS) begin
      level_field = 5'h00;
    end else if (d > `RB_CN0_MAX) begin
      level_field = 5'h1f;
    end else begin
      level_field = d[4:0];
    end
  endfunction

  // Header byte at index 0..8, counted after the start byte
  function automatic logic [7:0] hdr_byte(input blk_hdr_t h, input logic [3:0] i,
                                          input logic [15:0] len);
    hdr_byte = 8'h00;
    case (i)
      4'h0: hdr_byte = `RB_TYPE;
      4'h1: hdr_byte = len[15:8];
      4'h2: hdr_byte = len[7:0];
      4'h3: hdr_byte = h.week[15:8];
      4'h4: hdr_byte = h.week[7:0];
      4'h5: hdr_byte = h.tow[23:16];
      4'h6: hdr_byte = h.tow[15:8];
      4'h7: hdr_byte = h.tow[7:0];
      4'h8: hdr_byte = {`RB_PAR_SINGLE, `RB_PAR_RSVD, `RB_PAR_B3, `RB_PAR_B2, h.smooth};
      default: hdr_byte = 8'h00;
    endcase
  endfunction

  // Record byte at index 1..13; index 0 is taken straight from the FIFO
  function automatic logic [7:0] rec_byte(input sv_rec_t r, input logic [4:0] slips,
                                          input logic [3:0] i);
    logic [23:0] rate;
    rate = r.rate_bad ? `RB_RATE_BAD : r.rate;
    rec_byte = 8'h00;
    case (i)
      4'h1: rec_byte = r.prange[31:24];
      4'h2: rec_byte = r.prange[23:16];
      4'h3: rec_byte = r.prange[15:8];
      4'h4: rec_byte = r.prange[7:0];
      4'h5: rec_byte = {r.phase_bad, 2'b00, level_field(r.cn0)};
      4'h6: rec_byte = r.phase[23:16];
      4'h7: rec_byte = r.phase[15:8];
      4'h8: rec_byte = r.phase[7:0];
      4'h9: rec_byte = rate[23:16];
      4'ha: rec_byte = rate[15:8];
      4'hb: rec_byte = rate[7:0];
      4'hc: rec_byte = {r.phase_q, slips};
      4'hd: rec_byte = {r.pr_q, r.mp_known ? r.mp : `RB_MP_UNDET};
      default: rec_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Record FIFO
  // ----------------------------------------
  sv_rec_t f_data;
  logic f_valid;
  logic f_pop;

  rec_fifo #(
    .WIDTH($bits(sv_rec_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_data(i_rec),
    .i_valid(i_rec_valid),
    .o_ready(o_rec_ready),
    .o_data(f_data),
    .o_valid(f_valid),
    .i_ready(f_pop)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  frame_state_t state;
  blk_hdr_t hdr;
  sv_rec_t rec;
  logic [15:0] blen;
  logic [15:0] csum;
  logic [3:0] hidx;
  logic [3:0] ridx;
  logic [6:0] svleft;
  logic sidx;
  logic [4:0] slip_cnt [32];
  logic [4:0] cnt_q;
  logic esc_pend;
  logic [7:0] esc_code;

  logic [7:0] lb;
  logic lb_ok;
  logic content;
  logic load;
  logic step;
  logic [4:0] next_slips;

  // ----------------------------------------
  // Next logical (unescaped) byte
  // ----------------------------------------

  // Stalls at a record's first byte until the FIFO has one ready
  always_comb begin
    lb = 8'h00;
    lb_ok = 1'b1;
    content = 1'b1;
    case (state)
      ST_IDLE: begin
        lb_ok = 1'b0;
        content = 1'b0;
      end
      ST_SOB: begin
        lb = `RB_SOB;
        content = 1'b0;
      end
      ST_HDR: lb = hdr_byte(hdr, hidx, blen);
      ST_REC: begin
        if (ridx == 4'h0) begin
          lb = f_data.sv;
          lb_ok = f_valid;
        end else begin
          lb = rec_byte(rec, cnt_q, ridx);
        end
      end
      ST_SUM: lb = sidx ? csum[7:0] : csum[15:8];
      ST_EOB: begin
        lb = `RB_EOB;
        content = 1'b0;
      end
      default: begin
        lb_ok = 1'b0;
        content = 1'b0;
      end
    endcase
  end

  // Output register may take a byte when empty or being drained
  assign load = i_ce && (!o_byte_valid || i_byte_ready);
  // A logical byte is consumed only when no escape code is pending
  assign step = load && !esc_pend && lb_ok;
  assign f_pop = step && (state == ST_REC) && (ridx == 4'h0);
  // loss counter wraps naturally at 32
  assign next_slips = slip_cnt[f_data.sv[4:0]] + {4'h0, f_data.slip};

  // ----------------------------------------
  // Output byte with escaping
  // ----------------------------------------

  // reserved values split into marker and code
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_byte <= 8'h00;
      o_byte_valid <= 1'b0;
      esc_pend <= 1'b0;
      esc_code <= 8'h00;
    end else if (load) begin
      if (esc_pend) begin
        o_byte <= esc_code;
        o_byte_valid <= 1'b1;
        esc_pend <= 1'b0;
      end else if (lb_ok) begin
        o_byte_valid <= 1'b1;
        if (content && (lb >= `RB_ESC)) begin
          o_byte <= `RB_ESC;
          esc_pend <= 1'b1;
          esc_code <= lb - `RB_ESC;
        end else begin
          o_byte <= lb;
        end
      end else begin
        o_byte_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
      hdr <= '0;
      hidx <= 4'h0;
      ridx <= 4'h0;
      svleft <= 7'h00;
      sidx <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      if (state == ST_IDLE) begin
        if (i_start) begin
          hdr <= i_hdr;
          svleft <= i_hdr.nsv;
          hidx <= 4'h0;
          ridx <= 4'h0;
          sidx <= 1'b0;
          state <= ST_SOB;
          o_busy <= 1'b1;
        end
      end else if (step) begin
        case (state)
          ST_SOB: state <= ST_HDR;
          ST_HDR: begin
            hidx <= hidx + 4'h1;
            if (hidx == `RB_HDR_LAST) begin
              state <= (svleft == 7'h00) ? ST_SUM : ST_REC;
            end
          end
          ST_REC: begin
            if (ridx == `RB_REC_LAST) begin
              ridx <= 4'h0;
              svleft <= svleft - 7'h01;
              if (svleft == 7'h01) begin
                state <= ST_SUM;
              end
            end else begin
              ridx <= ridx + 4'h1;
            end
          end
          ST_SUM: begin
            sidx <= 1'b1;
            if (sidx) begin
              state <= ST_EOB;
            end
          end
          ST_EOB: begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // length fixed at start from the record count
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      blen <= 16'h0000;
    end else if (i_ce && (state == ST_IDLE) && i_start) begin
      blen <= `RB_HDR_LEN + 16'(i_hdr.nsv) * `RB_REC_LEN;
    end
  end

  // sum of unescaped header and record bytes
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      csum <= 16'h0000;
    end else if (i_ce) begin
      if ((state == ST_IDLE) && i_start) begin
        csum <= 16'h0000;
      end else if (step && ((state == ST_HDR) || (state == ST_REC))) begin
        csum <= csum + {8'h00, lb};
      end
    end
  end

  // Record latched as its first byte leaves, so the FIFO frees early
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rec <= '0;
    end else if (f_pop) begin
      rec <= f_data;
    end
  end

  // per-satellite loss counters, kept across blocks
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < 32; k++) begin
        slip_cnt[k] <= 5'h00;
      end
      cnt_q <= 5'h00;
    end else if (f_pop) begin
      slip_cnt[f_data.sv[4:0]] <= next_slips;
      cnt_q <= next_slips;
    end
  end

endmodule // raw_block_framer

`default_nettype wire

// [hdl/raw_block_params.svh]
// Constants for the raw measurement block framer: framing bytes,
// field layout, block geometry and fixed parameter-byte bits.
// Assumes inclusion by bare name from design files.
`ifndef RAW_BLOCK_PARAMS_SVH
`define RAW_BLOCK_PARAMS_SVH

// ----------------------------------------
// Framing bytes
// ----------------------------------------
`define RB_SOB 8'hfe
`define RB_EOB 8'hff
`define RB_ESC 8'hfd
`define RB_TYPE 8'h52

// ----------------------------------------
// Block geometry
// ----------------------------------------
`define RB_HDR_LEN 16'h0009
`define RB_REC_LEN 16'h000e
`define RB_HDR_LAST 4'h8
`define RB_REC_LAST 4'hd

// ----------------------------------------
// Field values
// ----------------------------------------
`define RB_CN0_OFS 8'h1a
`define RB_CN0_MAX 8'h1f
`define RB_RATE_BAD 24'h800000
`define RB_MP_UNDET 4'hf
`define RB_PAR_RSVD 3'h0
`define RB_PAR_B2 1'b1
`define RB_PAR_B3 1'b0
`define RB_PAR_SINGLE 1'b0
`define RB_FIFO_DEPTH 16

`endif

// [hdl/raw_block_pkg.sv]
// Types shared by the raw measurement block framer, its checker and its testbench.
// Assumes nothing of its surroundings.
package raw_block_pkg;

  // ----------------------------------------
  // Framer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SOB = 3'b001,
    ST_HDR = 3'b010,
    ST_REC = 3'b011,
    ST_SUM = 3'b100,
    ST_EOB = 3'b101
  } frame_state_t;

  // ----------------------------------------
  // Block header as given by the measurement side
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] week;
    logic [23:0] tow;
    logic [1:0] smooth;
    logic [6:0] nsv;
  } blk_hdr_t;

  // ----------------------------------------
  // One satellite measurement, before encoding
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] sv;
    logic [31:0] prange;
    logic [7:0] cn0;
    logic phase_bad;
    logic [23:0] phase;
    logic rate_bad;
    logic [23:0] rate;
    logic slip;
    logic [2:0] phase_q;
    logic mp_known;
    logic [3:0] mp;
    logic [3:0] pr_q;
  } sv_rec_t;

endpackage

// [hdl/rec_fifo.sv]
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ps
`default_nettype none

module rec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [WIDTH-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // Transfers only while enabled and both sides agree
  assign push = i_ce && i_valid && o_ready;
  assign pop = i_ce && o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  // Fill level after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage has no reset; flags say what is valid
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers and registered full/empty flags
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      o_ready <= (next_count != (AW + 1)'(DEPTH));
      o_valid <= (next_count != '0);
    end
  end

endmodule // rec_fifo

`default_nettype wire

// [testbench/raw_block_framer_chk.sv]
// Port checker for the raw measurement block framer.
// Assumes it is bound into every framer instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module raw_block_framer_chk #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_start,
  input wire raw_block_pkg::blk_hdr_t i_hdr,
  input wire logic o_rec_ready,
  input wire logic [7:0] o_byte,
  input wire logic o_byte_valid,
  input wire logic i_byte_ready,
  input wire logic o_busy
);
  import raw_block_pkg::*;
  logic acc;
  logic prev_fe;
  logic [15:0] exp_len;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  assign acc = i_ce && o_byte_valid && i_byte_ready;
  // Length latched at start, since the header may change later
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      exp_len <= 16'h0000;
    end else if (i_ce && i_start && !o_busy) begin
      exp_len <= 16'h0009 + 16'(i_hdr.nsv) * 16'h000e;
    end
  end
  // Remembers whether the last byte taken was the start marker
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_fe <= 1'b0;
    end else if (acc) begin
      prev_fe <= (o_byte == 8'hfe);
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_START_FE: assert property (i_ce && i_start && !o_busy && !o_byte_valid ##1 i_ce |=>
    o_busy && o_byte_valid && o_byte == 8'hfe) else $error("start marker missing");
  AST_HOLD: assert property (o_byte_valid && !(i_ce && i_byte_ready) |=>
    o_byte_valid && $stable(o_byte)) else $error("byte dropped before taken");
  AST_TYPE: assert property (acc && o_byte == 8'hfe |=>
    o_byte_valid && o_byte == 8'h52) else $error("type byte wrong");
  AST_LEN_HI: assert property (acc && prev_fe |=>
    o_byte_valid && o_byte == exp_len[15:8]) else $error("length high byte wrong");
  AST_ESC: assert property (acc && o_byte == 8'hfd |=>
    o_byte_valid && o_byte <= 8'h02) else $error("bad escape code");
  AST_END: assert property (acc && o_byte == 8'hff && !o_busy && !i_start |=>
    !o_byte_valid && !o_busy) else $error("stream goes on after end byte");
  AST_FREEZE: assert property (!i_ce |=> $stable(o_byte) && $stable(o_byte_valid)
    && $stable(o_busy) && $stable(o_rec_ready)) else $error("state moved while disabled");
  AST_BUSY: assert property (o_busy && i_ce |=>
    o_busy || (o_byte_valid && o_byte == 8'hff)) else $error("busy dropped inside block");
  COV_START: cover property (i_ce && i_start && !o_busy);
  COV_ESC: cover property (acc && o_byte == 8'hfd);
  COV_FULL: cover property (o_busy && !o_rec_ready);
endmodule // raw_block_framer_chk
bind raw_block_framer raw_block_framer_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_start(i_start),
  .i_hdr(i_hdr), .o_rec_ready(o_rec_ready), .o_byte(o_byte),
  .o_byte_valid(o_byte_valid), .i_byte_ready(i_byte_ready), .o_busy(o_busy));
`default_nettype wire

// [testbench/host_sink.sv]
// Host-side byte sink: takes framer bytes and undoes the escapes.
// Assumes the framer's clock; stall asks for random back-pressure.
`timescale 1ns/1ps
`default_nettype none
module host_sink (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_stall,
  input wire logic [7:0] i_byte,
  input wire logic i_valid,
  output logic o_ready,
  output logic [8:0] o_dec,
  output logic o_dec_valid
);
  logic esc;
  // Random ready while stalling, so holds are exercised mid-block
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= i_stall ? 1'($urandom_range(1)) : 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      esc <= 1'b0;
      o_dec_valid <= 1'b0;
      o_dec <= 9'h000;
    end else begin
      o_dec_valid <= 1'b0;
      if (i_ce && i_valid && o_ready) begin
        esc <= (i_byte == 8'hfd) && !esc;
        o_dec_valid <= esc || (i_byte != 8'hfd);
        o_dec <= esc ? {1'b0, 8'hfd + i_byte} : {i_byte >= 8'hfe, i_byte};
      end
    end
  end
endmodule // host_sink
`default_nettype wire

// [testbench/raw_block_framer_tb_top.sv]
// Testbench for the raw measurement block framer with a host sink.
// Assumes the checker is bound by its own file; bit 8 of a note marks FE/FF.
`timescale 1ns/1ps
`default_nettype none
module raw_block_framer_tb_top;
  import raw_block_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_start = 1'b0;
  blk_hdr_t i_hdr = '0;
  sv_rec_t i_rec = '0;
  logic i_rec_valid = 1'b0;
  logic stall = 1'b0;
  logic ce_jit = 1'b0;
  logic o_rec_ready, o_byte_valid, i_byte_ready, o_busy, dec_v;
  logic [7:0] o_byte;
  logic [8:0] dec;
  logic [8:0] exp_q[$];
  logic [4:0] loss[32];
  logic [15:0] sum;
  int err_total = 0;
  int cmp_count = 0;

  raw_block_framer dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_start(i_start), .i_hdr(i_hdr), .i_rec(i_rec), .i_rec_valid(i_rec_valid),
    .o_rec_ready(o_rec_ready), .o_byte(o_byte), .o_byte_valid(o_byte_valid),
    .i_byte_ready(i_byte_ready), .o_busy(o_busy));
  host_sink host (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_stall(stall), .i_byte(o_byte), .i_valid(o_byte_valid), .o_ready(i_byte_ready),
    .o_dec(dec), .o_dec_valid(dec_v));

  initial forever #10 i_ref_clk = ~i_ref_clk;
  // Clock enable gaps only when asked, to test freezing
  always @(posedge i_ref_clk) i_ce <= ce_jit ? ($urandom_range(9) != 0) : 1'b1;

  task automatic check(input logic [8:0] seen, input logic [8:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic bound(input int n);
    if (n >= 4000) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, n, 4000);
      report_and_stop();
    end
  endtask

  task automatic put(input logic [7:0] b);
    exp_q.push_back({1'b0, b});
    sum += 16'(b);
  endtask

  task automatic push(input sv_rec_t r);
    int n;
    i_rec <= r;
    i_rec_valid <= 1'b1;
    n = 0;
    do begin @(posedge i_ref_clk); n++; end while (!(i_ce && o_rec_ready) && n < 4000);
    bound(n);
  endtask

  // Builds the expected stream, then feeds header and records
  task automatic run(input int nsv, input logic [1:0] sm, input logic pre);
    sv_rec_t recs[$];
    sv_rec_t r;
    blk_hdr_t h;
    logic [7:0] lv;
    logic [15:0] len;
    logic [15:0] s;
    int k0;
    int n;
    h = {16'hfdfe ^ 16'(nsv), 24'($urandom), sm, 7'(nsv)};
    for (int j = 0; j < nsv; j++) begin
      r = 111'({$urandom, $urandom, $urandom, $urandom});
      r.sv = 8'($urandom_range(40));
      r.cn0 = 8'($urandom_range(64));
      recs.push_back(r);
    end
    // length and header fields, most significant first
    len = 16'h0009 + 16'h000e * 16'(nsv);
    exp_q.push_back(9'h1fe);
    sum = 16'h0000;
    put(8'h52); put(len[15:8]); put(len[7:0]);
    put(h.week[15:8]); put(h.week[7:0]); // week
    put(h.tow[23:16]); put(h.tow[15:8]); put(h.tow[7:0]); // tenths
    put({6'h01, sm}); // parameter
    foreach (recs[j]) begin
      r = recs[j];
      loss[r.sv[4:0]] += 5'(r.slip); // loss count
      lv = r.cn0 < 8'h1a ? 8'h00 : (r.cn0 > 8'h39 ? 8'h1f : r.cn0 - 8'h1a);
      put(r.sv); put(r.prange[31:24]); put(r.prange[23:16]);
      put(r.prange[15:8]); put(r.prange[7:0]);
      put({r.phase_bad, 2'b00, lv[4:0]}); // level
      put(r.phase[23:16]); put(r.phase[15:8]); put(r.phase[7:0]);
      if (r.rate_bad) r.rate = 24'h800000; // invalid rate
      put(r.rate[23:16]); put(r.rate[15:8]); put(r.rate[7:0]);
      put({r.phase_q, loss[r.sv[4:0]]});
      put({r.pr_q, r.mp_known ? r.mp : 4'hf});
    end
    s = sum;
    put(s[15:8]); put(s[7:0]);
    exp_q.push_back(9'h1ff);
    k0 = pre ? (nsv < 16 ? nsv : 16) : 0;
    for (int j = 0; j < k0; j++) push(recs[j]);
    i_rec_valid <= 1'b0;
    if (pre && nsv > 16) begin
      @(negedge i_ref_clk);
      check({8'h00, o_rec_ready}, 9'h000); // FIFO full refuses
      @(posedge i_ref_clk);
    end
    i_hdr <= h;
    i_start <= 1'b1;
    n = 0;
    do begin @(posedge i_ref_clk); n++; end while (!(i_ce && !o_busy) && n < 4000);
    bound(n);
    i_start <= 1'b0;
    for (int j = k0; j < nsv; j++) push(recs[j]);
    i_rec_valid <= 1'b0;
    n = 0;
    while ((exp_q.size() != 0 || o_busy) && n < 4000) begin
      @(posedge i_ref_clk);
      n++;
    end
    bound(n);
  endtask

  // Every decoded byte is matched against the oldest note
  always @(posedge i_ref_clk) begin
    if (dec_v) check(dec, exp_q.size() != 0 ? exp_q.pop_front() : ~dec);
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(52));
    foreach (loss[i]) loss[i] = 5'h00;
    repeat (2) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    check({8'h00, o_rec_ready}, 9'h001); // ready after reset
    @(posedge i_ref_clk);
    for (int k = 0; k < 4; k++) run(k, 2'(k), k[0]);
    stall <= 1'b1;
    ce_jit <= 1'b1;
    run(6, 2'h3, 1'b0);
    ce_jit <= 1'b0;
    run(17, 2'h1, 1'b1);
    report_and_stop();
  end
endmodule // raw_block_framer_tb_top
`default_nettype wire
